// file: design/emcc_top.sv
// mac configuration registers and the frame gating they steer
`timescale 1ns/100ps
module emcc_top #(
    parameter logic [15:0] MFL_RESET = emcc_pkg::MFL_RST,
    parameter logic [7:0] RETRY_RESET = emcc_pkg::RETRY_RST,
    parameter logic [7:0] COLL_RESET = emcc_pkg::COLL_RST
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [emcc_pkg::AW-1:0] addr_i,
    input wire logic [emcc_pkg::DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [emcc_pkg::DW-1:0] rdata_o,
    input wire logic rx_done_i,
    input wire logic [emcc_pkg::LW-1:0] rx_len_i,
    input wire logic rx_ctrl_i,
    input wire logic rx_pause_i,
    output logic rx_accept_o,
    output logic rx_pause_act_o,
    output logic rx_len_err_o,
    input wire logic tx_req_i,
    input wire logic [emcc_pkg::LW-1:0] tx_len_i,
    input wire logic tx_vlan_i,
    output logic tx_done_o,
    output logic [emcc_pkg::LW-1:0] tx_len_o,
    output logic tx_crc_o,
    output logic tx_abort_o,
    input wire logic pause_req_i,
    output logic pause_send_o,
    output logic full_duplex_o,
    output logic wait_medium_o,
    output logic [emcc_pkg::DW-1:0] b2b_gap_o,
    output logic [emcc_pkg::DW-1:0] nb2b_gap_low_o,
    output logic [emcc_pkg::DW-1:0] nb2b_gap_high_o,
    output logic [emcc_pkg::DW-1:0] retry_limit_o,
    output logic [emcc_pkg::DW-1:0] collision_window_o,
    output logic [47:0] station_addr_o
);
    localparam int DW = emcc_pkg::DW;
    localparam int LW = emcc_pkg::LW;

    logic [DW-1:0] rx_flow_reg;
    logic [DW-1:0] tx_frame_reg;
    logic [DW-1:0] wait_for_medium_reg;
    logic [LW-1:0] max_len_reg;
    logic [DW-1:0] b2b_reg;
    logic [DW-1:0] nb_lo_reg;
    logic [DW-1:0] nb_hi_reg;
    logic [DW-1:0] retry_reg;
    logic [DW-1:0] coll_reg;
    logic [DW-1:0] sa_reg [6];
    logic [DW-1:0] status_reg;
    logic [DW-1:0] status_next;
    logic [DW-1:0] rdata_next;
    logic [DW-1:0] st_set;

    // each register is written on its own address with no ordering among them
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_flow_reg <= emcc_pkg::ZERO_RST;
        end else if (wr_i && addr_i == emcc_pkg::REG_RXFC) begin
            // reserved and unused bits are never stored
            rx_flow_reg <= wdata_i & emcc_pkg::RXFC_MASK;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_frame_reg <= emcc_pkg::ZERO_RST;
            wait_for_medium_reg <= emcc_pkg::ZERO_RST;
        end else if (wr_i) begin
            if (addr_i == emcc_pkg::REG_TXFC) begin
                tx_frame_reg <= wdata_i;
            end
            if (addr_i == emcc_pkg::REG_WAIT_FOR_MEDIUM) begin
                wait_for_medium_reg <= wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            max_len_reg <= MFL_RESET;
        end else if (wr_i && addr_i == emcc_pkg::REG_MFL_LO) begin
            max_len_reg[DW-1:0] <= wdata_i;
        end else if (wr_i && addr_i == emcc_pkg::REG_MFL_HI) begin
            max_len_reg[LW-1:DW] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            b2b_reg <= emcc_pkg::ZERO_RST;
            nb_lo_reg <= emcc_pkg::ZERO_RST;
            nb_hi_reg <= emcc_pkg::ZERO_RST;
        end else if (wr_i) begin
            if (addr_i == emcc_pkg::REG_B2B) begin
                b2b_reg <= wdata_i;
            end
            if (addr_i == emcc_pkg::REG_NB_LO) begin
                nb_lo_reg <= wdata_i;
            end
            if (addr_i == emcc_pkg::REG_NB_HI) begin
                nb_hi_reg <= wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            retry_reg <= RETRY_RESET;
            coll_reg <= COLL_RESET;
        end else if (wr_i) begin
            if (addr_i == emcc_pkg::REG_RETRY) begin
                retry_reg <= wdata_i;
            end
            if (addr_i == emcc_pkg::REG_COLL) begin
                coll_reg <= wdata_i;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_sa
            localparam logic [emcc_pkg::AW-1:0] SA_ADDR =
                emcc_pkg::REG_SA0 + 5'(gi);
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    sa_reg[gi] <= emcc_pkg::ZERO_RST;
                end else if (wr_i && addr_i == SA_ADDR) begin
                    sa_reg[gi] <= wdata_i;
                end
            end
            // byte 0 is sent first on the wire, so it sits at the top
            assign station_addr_o[47-8*gi -: 8] = sa_reg[gi];
        end
    endgenerate

    emcc_rx_gate #(
        .LW(LW)
    ) u_rx (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .done_i(rx_done_i),
        .len_i(rx_len_i),
        .ctrl_i(rx_ctrl_i),
        .pause_i(rx_pause_i),
        .rx_en_i(rx_flow_reg[emcc_pkg::RXEN_BIT]),
        .pass_i(rx_flow_reg[emcc_pkg::PASS_BIT]),
        .prx_i(rx_flow_reg[emcc_pkg::PRX_BIT]),
        .lchk_i(tx_frame_reg[emcc_pkg::LEN_BIT]),
        .max_i(max_len_reg),
        .accept_o(rx_accept_o),
        .pause_act_o(rx_pause_act_o),
        .len_err_o(rx_len_err_o)
    );

    emcc_tx_pad #(
        .LW(LW)
    ) u_tx (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .req_i(tx_req_i),
        .len_i(tx_len_i),
        .vlan_i(tx_vlan_i),
        .pad_i(tx_frame_reg[emcc_pkg::PAD_MSB:emcc_pkg::PAD_LSB]),
        .crc_en_i(tx_frame_reg[emcc_pkg::CRC_BIT]),
        .max_i(max_len_reg),
        .done_o(tx_done_o),
        .len_o(tx_len_o),
        .crc_o(tx_crc_o),
        .abort_o(tx_abort_o)
    );

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pause_send_o <= 1'b0;
        end else begin
            // pause frames only make sense on a full duplex link
            pause_send_o <= pause_req_i && rx_flow_reg[emcc_pkg::PTX_BIT]
                && tx_frame_reg[emcc_pkg::FDX_BIT];
        end
    end

    assign full_duplex_o = tx_frame_reg[emcc_pkg::FDX_BIT];
    assign wait_medium_o = wait_for_medium_reg[emcc_pkg::WAIT_BIT];
    assign b2b_gap_o = b2b_reg;
    assign nb2b_gap_low_o = nb_lo_reg;
    assign nb2b_gap_high_o = nb_hi_reg;
    // the collision settings only drive a half duplex transmitter
    assign retry_limit_o = full_duplex_o ? '0 : retry_reg;
    assign collision_window_o = full_duplex_o ? '0 : coll_reg;

    always_comb begin
        st_set = '0;
        st_set[emcc_pkg::ST_RXOK] = rx_accept_o;
        st_set[emcc_pkg::ST_LERR] = rx_len_err_o;
        st_set[emcc_pkg::ST_PSEND] = pause_send_o;
        st_set[emcc_pkg::ST_TXAB] = tx_abort_o;
        status_next = status_reg;
        if (wr_i && addr_i == emcc_pkg::REG_STATUS) begin
            status_next = status_reg & ~wdata_i;
        end
        // an event in the clearing cycle survives the clear
        status_next = status_next | st_set;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_reg <= emcc_pkg::ZERO_RST;
        end else begin
            status_reg <= status_next;
        end
    end

    always_comb begin
        rdata_next = '0;
        case (addr_i)
            emcc_pkg::REG_RXFC: rdata_next = rx_flow_reg;
            emcc_pkg::REG_TXFC: rdata_next = tx_frame_reg;
            emcc_pkg::REG_WAIT_FOR_MEDIUM: rdata_next = wait_for_medium_reg;
            emcc_pkg::REG_MFL_LO: rdata_next = max_len_reg[DW-1:0];
            emcc_pkg::REG_MFL_HI: rdata_next = max_len_reg[LW-1:DW];
            emcc_pkg::REG_B2B: rdata_next = b2b_reg;
            emcc_pkg::REG_NB_LO: rdata_next = nb_lo_reg;
            emcc_pkg::REG_NB_HI: rdata_next = nb_hi_reg;
            emcc_pkg::REG_RETRY: rdata_next = retry_reg;
            emcc_pkg::REG_COLL: rdata_next = coll_reg;
            emcc_pkg::REG_STATUS: rdata_next = status_reg;
            default: begin
                if (addr_i >= emcc_pkg::REG_SA0
                    && addr_i <= emcc_pkg::REG_SA5) begin
                    rdata_next = sa_reg[3'(addr_i - emcc_pkg::REG_SA0)];
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= rd_i ? rdata_next : '0;
        end
    end

    AST_RXFC_TOP_ZERO: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        rd_i && addr_i == emcc_pkg::REG_RXFC |=> rdata_o[7:4] == 4'h0)
        else $error("unused receive flow bits read nonzero");
    AST_RXFC_STORE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_i && addr_i == emcc_pkg::REG_RXFC
        |=> rx_flow_reg == ($past(wdata_i) & 8'h0F))
        else $error("receive flow write not stored");
    AST_RX_ENABLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rx_done_i && rx_flow_reg[0] && !rx_ctrl_i
        && !tx_frame_reg[1] |=> rx_accept_o)
        else $error("data frame dropped while reception on");
    AST_PASS_CTRL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rx_done_i && rx_ctrl_i && !rx_flow_reg[1] |=> !rx_accept_o)
        else $error("control frame stored while filtered");
    AST_PAUSE_TX: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pause_send_o |-> $past(rx_flow_reg[3]) && $past(pause_req_i))
        else $error("pause frame sent while disabled");
    AST_PAUSE_RX: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rx_done_i && rx_pause_i && rx_flow_reg[0] && rx_flow_reg[2]
        |=> rx_pause_act_o)
        else $error("received pause frame not acted on");
    AST_LEN_CHECK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rx_done_i && rx_flow_reg[0] && tx_frame_reg[1]
        && rx_len_i > max_len_reg |=> rx_len_err_o ##1 status_reg[1])
        else $error("overlong frame not reported");
    AST_TX_MAX: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        tx_req_i && tx_len_i > max_len_reg |=> tx_abort_o)
        else $error("overlong transmit not stopped");
    AST_PAD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        tx_req_i && tx_frame_reg[5] && tx_len_i < 16'h003C
        |=> tx_len_o >= 16'h003C && tx_crc_o)
        else $error("short frame left unpadded");
    AST_COLL_HALF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_i && addr_i == emcc_pkg::REG_COLL && !full_duplex_o
        |=> collision_window_o == $past(wdata_i))
        else $error("collision window write not seen in half duplex");
    AST_STICKY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rx_accept_o |=> status_reg[0])
        else $error("accepted frame lost from status");
    // the two length bytes sit at separate addresses, so a write to the high
    // byte must leave the low byte of the limit as it was
    AST_MFL_SPLIT: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        wr_i && addr_i == emcc_pkg::REG_MFL_HI
        |=> max_len_reg[7:0] == $past(max_len_reg[7:0]))
        else $error("high length byte write disturbed low byte");
    AST_PAUSE_OFF: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        pause_req_i && !rx_flow_reg[3] |=> !pause_send_o)
        else $error("pause frame sent while pause transmit off");

    COV_RX: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        rx_accept_o);
    COV_PAUSE: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        rx_pause_act_o ##[1:20] pause_send_o);
    COV_PADDED: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        tx_done_o && tx_len_o == 16'h0040);
    COV_CLR: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_i && addr_i == emcc_pkg::REG_STATUS && |st_set);
    COV_HALF_COLL: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        !full_duplex_o && collision_window_o != emcc_pkg::COLL_RST);
endmodule

// file: design/emcc_pkg.sv
// constants and register map of the mac configuration and control block
// How it works
// - settings are taken once at start, in any order, with no dependency.
// - receive enable bit 0 set lets the mac accept frames; clear blocks reception.
// - pause transmit enable bit 3 gates sending of pause control frames.
// - pause receive enable bit 2 makes received pause frames act; clear ignores them.
// - pass control frames bit 1 stores unconsumed control frames; clear drops them.
// - upper four bits of the receive flow register always read zero.
// - length check enable makes the mac check and report received frame length.
// - programmed maximum frame length limits received and transmitted frames.
// - half duplex uses retry limit and collision window; defaults usually suffice.
// - pad setting makes the transmitter zero pad short frames, else host pads.
package emcc_pkg;
    localparam int AW = 5;
    localparam int DW = 8;
    localparam int LW = 16;
    localparam logic [AW-1:0] REG_RXFC = 5'h00;
    localparam logic [AW-1:0] REG_TXFC = 5'h01;
    localparam logic [AW-1:0] REG_WAIT_FOR_MEDIUM = 5'h02;
    localparam logic [AW-1:0] REG_MFL_LO = 5'h03;
    localparam logic [AW-1:0] REG_MFL_HI = 5'h04;
    localparam logic [AW-1:0] REG_B2B = 5'h05;
    localparam logic [AW-1:0] REG_NB_LO = 5'h06;
    localparam logic [AW-1:0] REG_NB_HI = 5'h07;
    localparam logic [AW-1:0] REG_RETRY = 5'h08;
    localparam logic [AW-1:0] REG_COLL = 5'h09;
    localparam logic [AW-1:0] REG_SA0 = 5'h0A;
    localparam logic [AW-1:0] REG_SA5 = 5'h0F;
    localparam logic [AW-1:0] REG_STATUS = 5'h10;
    // receive flow register fields
    localparam int RXEN_BIT = 0;
    localparam int PASS_BIT = 1;
    localparam int PRX_BIT = 2;
    localparam int PTX_BIT = 3;
    localparam logic [DW-1:0] RXFC_MASK = 8'h0F;
    // transmit frame register fields, then the wait for medium register bit
    localparam int FDX_BIT = 0;
    localparam int LEN_BIT = 1;
    localparam int CRC_BIT = 4;
    localparam int PAD_LSB = 5;
    localparam int PAD_MSB = 7;
    localparam int WAIT_BIT = 0;
    // status fields, sticky, write one to clear
    localparam int ST_RXOK = 0;
    localparam int ST_LERR = 1;
    localparam int ST_PSEND = 2;
    localparam int ST_TXAB = 3;
    localparam logic [DW-1:0] ZERO_RST = 8'h00;
    localparam logic [LW-1:0] MFL_RST = 16'h05EE;
    localparam logic [DW-1:0] RETRY_RST = 8'h0F;
    localparam logic [DW-1:0] COLL_RST = 8'h3F;
    localparam logic [LW-1:0] PAD_SHORT = 16'h003C;
    localparam logic [LW-1:0] PAD_LONG = 16'h0040;
endpackage

// file: design/emcc_rx_gate.sv
// receive decision: accept, pause action and length check per frame
`timescale 1ns/100ps
module emcc_rx_gate #(
    parameter int LW = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic done_i,
    input wire logic [LW-1:0] len_i,
    input wire logic ctrl_i,
    input wire logic pause_i,
    input wire logic rx_en_i,
    input wire logic pass_i,
    input wire logic prx_i,
    input wire logic lchk_i,
    input wire logic [LW-1:0] max_i,
    output logic accept_o,
    output logic pause_act_o,
    output logic len_err_o
);
    if (LW < 8) begin : g_lw_check
        $error("length width too small");
    end
    logic too_long;
    logic keep;
    assign too_long = lchk_i && (len_i > max_i);
    // a control frame the mac consumed (pause) never reaches the buffer
    assign keep = !ctrl_i || (pass_i && !(pause_i && prx_i));
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            accept_o <= 1'b0;
        end else begin
            accept_o <= done_i && rx_en_i && keep && !too_long;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pause_act_o <= 1'b0;
        end else begin
            pause_act_o <= done_i && rx_en_i && pause_i && prx_i;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            len_err_o <= 1'b0;
        end else begin
            len_err_o <= done_i && rx_en_i && too_long;
        end
    end
    AST_RX_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !rx_en_i |=> !accept_o)
        else $error("frame accepted while reception is off");
    AST_PAUSE_IGN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        done_i && !prx_i |=> !pause_act_o)
        else $error("pause frame acted on while ignored");
endmodule

// file: design/emcc_tx_pad.sv
// transmit padding, crc append and maximum length guard per frame
`timescale 1ns/100ps
module emcc_tx_pad #(
    parameter int LW = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic req_i,
    input wire logic [LW-1:0] len_i,
    input wire logic vlan_i,
    input wire logic [2:0] pad_i,
    input wire logic crc_en_i,
    input wire logic [LW-1:0] max_i,
    output logic done_o,
    output logic [LW-1:0] len_o,
    output logic crc_o,
    output logic abort_o
);
    if (LW < 8) begin : g_lw_check
        $error("length width too small");
    end
    logic pad_on;
    logic [LW-1:0] pad_to;
    // odd codes pad; bit 1, or bit 2 on a tagged frame, pads to the long size
    assign pad_on = pad_i[0];
    assign pad_to = (pad_i[1] || (pad_i[2] && vlan_i)) ?
        emcc_pkg::PAD_LONG : emcc_pkg::PAD_SHORT;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_o <= 1'b0;
            len_o <= '0;
            crc_o <= 1'b0;
            abort_o <= 1'b0;
        end else begin
            done_o <= req_i;
            abort_o <= req_i && (len_i > max_i);
            if (req_i) begin
                len_o <= (pad_on && len_i < pad_to) ? pad_to : len_i;
                crc_o <= pad_on || crc_en_i;
            end
        end
    end
    AST_PAD_MIN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        req_i && pad_i == 3'h1 |=> len_o >= emcc_pkg::PAD_SHORT)
        else $error("short frame not padded");
endmodule

// file: tb/emcc_host_model.sv
// host side model: register bus master and the recommended start-up program
`timescale 1ns/100ps
module emcc_host_model (
    input wire logic clk_i,
    output logic [emcc_pkg::AW-1:0] addr_o,
    output logic [emcc_pkg::DW-1:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    input wire logic [emcc_pkg::DW-1:0] rdata_i
);
    initial begin
        addr_o = 5'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        // stale data would hide a decoder that ignores the strobe
        wdata_o <= ~d;
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        // read data stand only in the cycle after the strobe
        #1;
        d = rdata_i;
    endtask
    // settings go out once, deliberately not in address order
    task automatic init(input logic fdx, input logic [47:0] sa);
        int i;
        for (i = 0; i < 6; i++) begin
            wr(5'(emcc_pkg::REG_SA0 + i), sa[47-8*i -: 8]);
        end
        wr(emcc_pkg::REG_NB_LO, 8'h12);
        wr(emcc_pkg::REG_B2B, fdx ? 8'h15 : 8'h12);
        if (!fdx) begin
            wr(emcc_pkg::REG_NB_HI, 8'h0C);
        end
        wr(emcc_pkg::REG_WAIT_FOR_MEDIUM, 8'h01);
        wr(emcc_pkg::REG_TXFC, {3'b001, 4'b1001, fdx});
        wr(emcc_pkg::REG_RXFC, {4'h0, fdx, fdx, 2'b01});
    endtask
endmodule

// file: tb/tb.sv
// self-checking bench of the mac configuration and control block
`timescale 1ns/100ps
module tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [4:0] addr;
    logic [7:0] wdata, rdata, b2b, nbl, nbh, rty, col;
    logic wr, rd, rx_done, rx_ctrl, rx_pause, acc, pact, lerr;
    logic [15:0] rx_len, tx_len, tx_len_o;
    logic tx_req, tx_vlan, tx_done, tx_crc, tx_abort;
    logic pause_req, pause_send, fdx, wmed;
    logic [47:0] sa;
    int fails = 0;
    int num_checks = 0;
    int cyc = 0;
    always #2 clk_i = ~clk_i;
    emcc_top emcc_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .rx_done_i(rx_done), .rx_len_i(rx_len),
        .rx_ctrl_i(rx_ctrl), .rx_pause_i(rx_pause), .rx_accept_o(acc),
        .rx_pause_act_o(pact), .rx_len_err_o(lerr), .tx_req_i(tx_req),
        .tx_len_i(tx_len), .tx_vlan_i(tx_vlan), .tx_done_o(tx_done),
        .tx_len_o(tx_len_o), .tx_crc_o(tx_crc), .tx_abort_o(tx_abort),
        .pause_req_i(pause_req), .pause_send_o(pause_send),
        .full_duplex_o(fdx), .wait_medium_o(wmed), .b2b_gap_o(b2b),
        .nb2b_gap_low_o(nbl), .nb2b_gap_high_o(nbh),
        .retry_limit_o(rty), .collision_window_o(col),
        .station_addr_o(sa));
    emcc_host_model emcc_host_model_inst (.clk_i(clk_i), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            give_verdict();
        end
    end
    task automatic chk(string n, logic [47:0] e, logic [47:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        emcc_host_model_inst.wr(a, d);
    endtask
    task automatic rchk(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] d;
        emcc_host_model_inst.rd(a, d);
        chk($sformatf("reg %h", a), {40'h0, e}, {40'h0, d});
    endtask
    task automatic rxc(logic lc, logic [3:0] rf, logic ct, logic ps,
            logic [15:0] len, logic [2:0] e);
        wr_reg(emcc_pkg::REG_TXFC, {6'b001100, lc, 1'b1});
        wr_reg(emcc_pkg::REG_RXFC, {4'h0, rf});
        @(posedge clk_i);
        rx_done <= 1'b1;
        rx_len <= len;
        rx_ctrl <= ct;
        rx_pause <= ps;
        @(posedge clk_i);
        rx_done <= 1'b0;
        #1;
        chk("rx flags", {45'h0, e}, {45'h0, acc, pact, lerr});
    endtask
    task automatic txc(logic [15:0] len, logic v, logic [15:0] el,
            logic ec, logic ea);
        @(posedge clk_i);
        tx_req <= 1'b1;
        tx_len <= len;
        tx_vlan <= v;
        @(posedge clk_i);
        tx_req <= 1'b0;
        #1;
        chk("tx flags", {45'h0, 1'b1, ec, ea}, {45'h0, tx_done, tx_crc,
            tx_abort});
        if (!ea) chk("tx len", {32'h0, el}, {32'h0, tx_len_o});
    endtask
    task automatic psc(logic [7:0] rf, logic [7:0] tf, logic e);
        wr_reg(emcc_pkg::REG_RXFC, rf);
        wr_reg(emcc_pkg::REG_TXFC, tf);
        @(posedge clk_i);
        pause_req <= 1'b1;
        @(posedge clk_i);
        pause_req <= 1'b0;
        #1;
        chk("pause send", {47'h0, e}, {47'h0, pause_send});
    endtask
    initial begin
        logic [7:0] e;
        logic [2:0] pc;
        logic [15:0] el;
        int p, v;
        {rx_done, rx_ctrl, rx_pause, tx_req, tx_vlan, pause_req} = 6'h00;
        rx_len = 16'h0000;
        tx_len = 16'h0000;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        chk("retry", 48'h0F, {40'h0, rty});
        chk("collision", 48'h3F, {40'h0, col});
        wr_reg(5'h15, 8'hFF);
        for (p = 0; p < 32; p++) begin
            e = p == 3 ? 8'hEE : p == 4 ? 8'h05 : p == 8 ? 8'h0F :
                p == 9 ? 8'h3F : 8'h00;
            rchk(5'(p), e);
        end
        wr_reg(emcc_pkg::REG_RXFC, 8'hFF);
        rchk(emcc_pkg::REG_RXFC, 8'h0F);
        $display("test reset and map done");
        emcc_host_model_inst.init(1'b1, 48'h0A1B2C3D4E5F);
        chk("b2b", 48'h15, {40'h0, b2b});
        chk("nb low", 48'h12, {40'h0, nbl});
        chk("station", 48'h0A1B2C3D4E5F, sa);
        chk("modes", 48'h3, {46'h0, fdx, wmed});
        chk("fdx retry", 48'h0, {32'h0, rty, col});
        rchk(emcc_pkg::REG_SA5, 8'h5F);
        $display("test full duplex init done");
        rxc(0, 4'h1, 0, 0, 16'd64, 3'b100);
        rxc(1, 4'h0, 0, 0, 16'd64, 3'b000);
        rxc(1, 4'h1, 1, 1, 16'd64, 3'b000);
        rxc(1, 4'h5, 1, 1, 16'd64, 3'b010);
        rxc(1, 4'h3, 1, 0, 16'd64, 3'b100);
        rxc(1, 4'h1, 1, 0, 16'd64, 3'b000);
        rxc(1, 4'h3, 1, 1, 16'd64, 3'b100);
        rxc(1, 4'h1, 0, 0, 16'd1519, 3'b001);
        rxc(1, 4'h1, 0, 0, 16'd1518, 3'b100);
        wr_reg(emcc_pkg::REG_MFL_LO, 8'h40);
        wr_reg(emcc_pkg::REG_MFL_HI, 8'h00);
        rxc(1, 4'h1, 0, 0, 16'd65, 3'b001);
        rxc(1, 4'h1, 0, 0, 16'd64, 3'b100);
        rchk(emcc_pkg::REG_STATUS, 8'h03);
        wr_reg(emcc_pkg::REG_STATUS, 8'h03);
        rchk(emcc_pkg::REG_STATUS, 8'h00);
        $display("test receive done");
        for (p = 0; p < 8; p++) begin
            pc = 3'(p);
            wr_reg(emcc_pkg::REG_TXFC, {pc, 5'b00011});
            for (v = 0; v < 2; v++) begin
                el = !pc[0] ? 16'h0014 : (pc == 3'h5 && v == 0) ||
                    pc == 3'h1 ? 16'h003C : 16'h0040;
                txc(16'h0014, v[0], el, pc[0], 1'b0);
            end
        end
        wr_reg(emcc_pkg::REG_MFL_HI, 8'h05);
        wr_reg(emcc_pkg::REG_MFL_LO, 8'hEE);
        wr_reg(emcc_pkg::REG_TXFC, 8'h13);
        txc(16'd1518, 1'b0, 16'd1518, 1'b1, 1'b0);
        txc(16'd1519, 1'b0, 16'd0, 1'b1, 1'b1);
        $display("test transmit done");
        psc(8'h08, 8'h01, 1'b1);
        psc(8'h00, 8'h01, 1'b0);
        psc(8'h08, 8'h00, 1'b0);
        rchk(emcc_pkg::REG_STATUS, 8'h0C);
        $display("test pause send done");
        emcc_host_model_inst.init(1'b0, 48'h0A1B2C3D4E5F);
        chk("hdx gaps", 48'h120C, {32'h0, b2b, nbh});
        chk("hdx retry", 48'h0F3F, {32'h0, rty, col});
        wr_reg(emcc_pkg::REG_COLL, 8'h7F);
        #1;
        chk("collision", 48'h7F, {40'h0, col});
        $display("test half duplex done");
        give_verdict();
    end
endmodule
